// ---- pkg/np_partner_pkg.sv ----
// Purpose: Shared constants for the next page partner ability register block.
// Assumes: 32-bit AXI4-Lite data; every register index maps to byte address 4 * index.
// Notes: Register indices are word indices; byte address is the index shifted left by two.
package np_partner_pkg;
  // ===========================================================
  // Register map
  localparam int REG_W = 16;
  localparam int IDX_W = 6;
  localparam logic [5:0] IDX_EXPANSION = 6'h06;
  localparam logic [5:0] IDX_PARTNER = 6'h08;
  localparam logic [5:0] IDX_CONTROL = 6'h11;
  localparam logic [5:0] IDX_STATUS = 6'h12;
  // ===========================================================
  // Field positions
  localparam int BIT_MORE_PAGES = 15;
  localparam int BIT_RESERVED = 14;
  localparam int BIT_FORMAT = 13;
  localparam int BIT_SECOND_ACKNOWLEDGE = 12;
  localparam int BIT_TOGGLE = 11;
  localparam int CODE_MSB = 10;
  localparam int BIT_PAGE_RX = 1;
  localparam int BIT_ACCEPT_EN = 0;
  localparam int BIT_TOGGLE_ERR = 0;
  localparam int BIT_EXP_TOGGLE = 1;
  localparam int BIT_ARMED = 2;
  // ===========================================================
  // Reset values and bus answers
  localparam logic [15:0] PARTNER_RESET = 16'h0000;
  localparam logic [15:0] CONTROL_RESET = 16'h0001;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : np_partner_pkg

// ---- core/page_word_store.sv ----
// Purpose: Holds one received link code word, loaded as a whole.
// Assumes: Load is a one-cycle strobe from the same clock domain.
// Notes: Read data come straight from the storage flip-flops.
`timescale 1ns/100ps
module page_word_store #(
  parameter int WIDTH = 16
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic load,
  input wire logic [WIDTH-1:0] loadWord,
  output logic [WIDTH-1:0] word_reg
);
  initial begin
    if (WIDTH < 1) begin
      $error("page_word_store: WIDTH must be at least one");
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      word_reg <= '0;
    end else if (load) begin
      word_reg <= loadWord;
    end
  end
endmodule : page_word_store

// ---- core/next_page_partner_ability_reg.sv ----
// Purpose: Partner next page ability register with AXI4-Lite access and page-received flag.
// Assumes: Page and base strobes come from arbitration logic on clk, one cycle each.
// Notes: Pages are accepted only after a base page and only with the expected toggle.
// Function
// - Sixteen-bit read-only register at index 0x08, all bits reset to zero.
// - Bit 15 shows the partner's more-pages flag.
// - Bit 14 is reserved and always reads zero.
// - Bit 13 shows page format: message page when one.
// - Bit 12 shows the partner's second acknowledge.
// - Each next page toggle is the inverse of the previous word's toggle.
// - First next page toggle is the inverse of base word bit 11.
// - Bits 10 to 0 hold the message or unformatted code field.
// - Storing a page sets page-received; reading expansion clears it.
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/100ps
module next_page_partner_ability_reg
  import np_partner_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [15:0] baseWord,
  input wire logic baseValid,
  input wire logic [15:0] pageWord,
  input wire logic pageValid,
  output logic pageReceived_reg,
  output logic morePages_reg
);
  initial begin
    if (ADDR_W < IDX_W + 2) begin
      $error("next_page_partner_ability_reg: ADDR_W too small for the map");
    end
  end

  // ===========================================================
  // Page capture
  logic [15:0] storedWord;
  logic acceptEn_reg;
  logic armed_reg;
  logic expToggle_reg;
  logic toggleErr_reg;
  logic pageSeen;
  logic pageAccept;
  logic pageMismatch;
  logic [15:0] pageClean;

  assign pageSeen = pageValid && acceptEn_reg && armed_reg;
  assign pageAccept = pageSeen && (pageWord[BIT_TOGGLE] == expToggle_reg);
  assign pageMismatch = pageSeen && (pageWord[BIT_TOGGLE] != expToggle_reg);

  always_comb begin
    pageClean = pageWord;
    pageClean[BIT_RESERVED] = 1'b0;
  end

  page_word_store #(.WIDTH(REG_W)) store (
    .clk(clk),
    .reset(reset),
    .load(pageAccept),
    .loadWord(pageClean),
    .word_reg(storedWord)
  );

  // A base page restarts the sequence, so it sets the expected toggle even when a page is stored in the same cycle.
  always_ff @(posedge clk) begin
    if (reset) begin
      expToggle_reg <= 1'b0;
      armed_reg <= 1'b0;
    end else if (baseValid) begin
      expToggle_reg <= ~baseWord[BIT_TOGGLE];
      armed_reg <= 1'b1;
    end else if (pageAccept) begin
      expToggle_reg <= ~pageWord[BIT_TOGGLE];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      morePages_reg <= 1'b0;
    end else if (pageAccept) begin
      morePages_reg <= pageWord[BIT_MORE_PAGES];
    end
  end

  // ===========================================================
  // AXI4-Lite write channel
  logic awHeld_reg;
  logic wHeld_reg;
  logic [IDX_W-1:0] wIdx_reg;
  logic [31:0] wData_reg;
  logic [3:0] wStrb_reg;
  logic doWrite;

  assign doWrite = awHeld_reg && wHeld_reg && !bvalid;

  function automatic logic mapped(input logic [IDX_W-1:0] idx);
    mapped = (idx == IDX_EXPANSION) || (idx == IDX_PARTNER) ||
             (idx == IDX_CONTROL) || (idx == IDX_STATUS);
  endfunction : mapped

  always_ff @(posedge clk) begin
    if (reset) begin
      awHeld_reg <= 1'b0;
      awready <= 1'b1;
      wIdx_reg <= '0;
    end else if (awvalid && awready) begin
      awHeld_reg <= 1'b1;
      awready <= 1'b0;
      wIdx_reg <= awaddr[IDX_W+1:2];
    end else if (doWrite) begin
      awHeld_reg <= 1'b0;
      awready <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wHeld_reg <= 1'b0;
      wready <= 1'b1;
      wData_reg <= '0;
      wStrb_reg <= '0;
    end else if (wvalid && wready) begin
      wHeld_reg <= 1'b1;
      wready <= 1'b0;
      wData_reg <= wdata;
      wStrb_reg <= wstrb;
    end else if (doWrite) begin
      wHeld_reg <= 1'b0;
      wready <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (doWrite) begin
      bvalid <= 1'b1;
      bresp <= mapped(wIdx_reg) ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid && bready) begin
      bvalid <= 1'b0;
    end
  end

  // Read-only registers ignore writes; software is expected to write reserved defaults.
  always_ff @(posedge clk) begin
    if (reset) begin
      acceptEn_reg <= CONTROL_RESET[BIT_ACCEPT_EN];
    end else if (doWrite && wIdx_reg == IDX_CONTROL && wStrb_reg[0]) begin
      acceptEn_reg <= wData_reg[BIT_ACCEPT_EN];
    end
  end

  // ===========================================================
  // AXI4-Lite read channel
  logic readTake;
  logic [IDX_W-1:0] rIdx;
  logic [15:0] readWord;

  assign readTake = arvalid && arready;
  assign rIdx = araddr[IDX_W+1:2];

  always_comb begin
    readWord = '0;
    case (rIdx)
      IDX_EXPANSION: readWord[BIT_PAGE_RX] = pageReceived_reg;
      IDX_PARTNER: readWord = storedWord;
      IDX_CONTROL: readWord[BIT_ACCEPT_EN] = acceptEn_reg;
      IDX_STATUS: begin
        readWord[BIT_TOGGLE_ERR] = toggleErr_reg;
        readWord[BIT_EXP_TOGGLE] = expToggle_reg;
        readWord[BIT_ARMED] = armed_reg;
      end
      default: readWord = '0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else if (readTake) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= {16'h0000, readWord};
      rresp <= mapped(rIdx) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
    end
  end

  // ===========================================================
  // Latching status flags; a set in the clearing cycle wins.
  always_ff @(posedge clk) begin
    if (reset) begin
      pageReceived_reg <= 1'b0;
    end else if (pageAccept) begin
      pageReceived_reg <= 1'b1;
    end else if (readTake && rIdx == IDX_EXPANSION) begin
      pageReceived_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      toggleErr_reg <= 1'b0;
    end else if (pageMismatch) begin
      toggleErr_reg <= 1'b1;
    end else if (readTake && rIdx == IDX_STATUS) begin
      toggleErr_reg <= 1'b0;
    end
  end

  // ===========================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  reset_zero_a: assert property ($fell(reset) |-> storedWord == PARTNER_RESET)
    else $error("partner word not zero after reset");
  more_pages_a: assert property (pageAccept |=> morePages_reg == $past(pageWord[BIT_MORE_PAGES]))
    else $error("more pages flag not captured");
  reserved_zero_a: assert property (rvalid && $past(readTake) |-> rdata[BIT_RESERVED] == 1'b0)
    else $error("reserved bit read as one");
  format_flag_a: assert property (pageAccept |=> storedWord[13] == $past(pageWord[13]))
    else $error("format flag not captured");
  ack_two_a: assert property (pageAccept |=> storedWord[12] == $past(pageWord[12]))
    else $error("second acknowledge not captured");
  toggle_chain_a: assert property (pageAccept && !baseValid |=> expToggle_reg != storedWord[11])
    else $error("expected toggle not inverted");
  first_toggle_a: assert property (baseValid |=> expToggle_reg == !$past(baseWord[11]))
    else $error("first toggle not inverse of base bit");
  code_field_a: assert property (pageAccept |=> storedWord[10:0] == $past(pageWord[10:0]))
    else $error("code field not captured");
  page_rx_a: assert property (pageAccept |=> pageReceived_reg)
    else $error("page received not set");
  whole_word_a: assert property (!pageAccept |=> $stable(storedWord))
    else $error("partner word changed without a page");
endmodule : next_page_partner_ability_reg

// ---- bench/link_partner_model.sv ----
// Purpose: Link partner model that hands base and next page words to the block.
// Assumes: Each word lasts one cycle and is driven right after a rising edge.
// Notes: After each word both idle word lines are inverted, so the line just used shows the inverse of its word.
`timescale 1ns/100ps
module link_partner_model (
  input wire logic clk,
  output logic [15:0] baseWord,
  output logic baseValid,
  output logic [15:0] pageWord,
  output logic pageValid
);
  initial begin
    baseWord = 16'h0000;
    baseValid = 1'b0;
    pageWord = 16'h0000;
    pageValid = 1'b0;
  end
  // ===========================================================
  // Word strobe
  // whole word strobe
  task automatic send_word(input logic isBase, input logic [15:0] w);
    @(posedge clk);
    baseValid <= isBase;
    pageValid <= !isBase;
    if (isBase) begin
      baseWord <= w;
    end else begin
      pageWord <= w;
    end
    @(posedge clk);
    baseValid <= 1'b0;
    pageValid <= 1'b0;
    baseWord <= ~baseWord;
    pageWord <= ~pageWord;
  endtask : send_word
endmodule : link_partner_model

// ---- bench/tb_next_page_partner_ability_reg.sv ----
// Purpose: Self-checking bench for the partner next page ability register.
// Assumes: Registers are reached through AXI4-Lite at byte address 4 * index.
// Notes: Every wait on the bus is bounded; a watchdog ends a hung run.
`timescale 1ns/100ps
module tb_next_page_partner_ability_reg import np_partner_pkg::*;;
  localparam logic [7:0] A_PART = {IDX_PARTNER, 2'b00};
  localparam logic [7:0] A_EXP = {IDX_EXPANSION, 2'b00};
  localparam logic [7:0] A_CTRL = {IDX_CONTROL, 2'b00};
  localparam logic [7:0] A_STAT = {IDX_STATUS, 2'b00};
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  logic [15:0] baseWord;
  logic baseValid;
  logic [15:0] pageWord;
  logic pageValid;
  logic pageReceived_reg;
  logic morePages_reg;
  int err_total = 0;
  int n_compared = 0;
  always #5 clk = ~clk;
  next_page_partner_ability_reg next_page_partner_ability_reg_inst (
    .clk, .reset, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .baseWord, .baseValid, .pageWord, .pageValid, .pageReceived_reg,
    .morePages_reg
  );
  link_partner_model partner (.clk, .baseWord, .baseValid, .pageWord, .pageValid);
  // ===========================================================
  // Bus tasks
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic done;
    n = 0;
    done = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done && n < 100) begin
      @(posedge clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        bready <= 1'b0;
        done = 1'b1;
        chk({32'h0, bresp}, {32'h0, er});
      end
    end
    if (!done) begin
      err_total++;
      $display("wrong value at %0t ns: got %h expected %h", $time, 1'b0, 1'b1);
    end
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    logic done;
    n = 0;
    done = 1'b0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done && n < 100) begin
      @(posedge clk);
      n++;
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        rready <= 1'b0;
        done = 1'b1;
        chk({rresp, rdata}, {er, e});
      end
    end
    if (!done) begin
      err_total++;
      $display("wrong value at %0t ns: got %h expected %h", $time, 1'b0, 1'b1);
    end
  endtask : rd_chk
  task automatic done_test(input string s);
    $display("test %s finished at %0t ns", s, $time);
  endtask : done_test
  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : print_verdict
  // ===========================================================
  // Tests
  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    rd_chk(A_PART, 32'h0, RESP_OKAY);
    rd_chk(A_EXP, 32'h0, RESP_OKAY);
    partner.send_word(1'b0, 16'h0800);
    rd_chk(A_PART, 32'h0, RESP_OKAY);
    wr(A_PART, 32'h0000BDA5, RESP_OKAY);
    rd_chk(A_PART, 32'h0, RESP_OKAY);
    wr(8'h3C, 32'h0, RESP_SLVERR);
    rd_chk(8'h3C, 32'h0, RESP_SLVERR);
    done_test("reset and access");
    partner.send_word(1'b1, 16'h0000);
    partner.send_word(1'b0, 16'hBDA5);
    rd_chk(A_PART, 32'h0000BDA5, RESP_OKAY);
    chk({32'h0, morePages_reg, pageReceived_reg}, {32'h0, 2'b11});
    rd_chk(A_EXP, 32'h2, RESP_OKAY);
    rd_chk(A_EXP, 32'h0, RESP_OKAY);
    partner.send_word(1'b0, 16'h4123);
    rd_chk(A_PART, 32'h0123, RESP_OKAY);
    partner.send_word(1'b0, 16'h2456);
    rd_chk(A_PART, 32'h0123, RESP_OKAY);
    rd_chk(A_STAT, 32'h7, RESP_OKAY);
    rd_chk(A_STAT, 32'h6, RESP_OKAY);
    done_test("page toggle");
    partner.send_word(1'b1, 16'h0800);
    partner.send_word(1'b0, 16'h17FF);
    rd_chk(A_PART, 32'h17FF, RESP_OKAY);
    chk({32'h0, morePages_reg, pageReceived_reg}, {32'h0, 2'b01});
    wr(A_CTRL, 32'h0, RESP_OKAY);
    partner.send_word(1'b0, 16'h8800);
    rd_chk(A_PART, 32'h17FF, RESP_OKAY);
    rd_chk(A_CTRL, 32'h0, RESP_OKAY);
    wr(A_CTRL, 32'h1, RESP_OKAY);
    done_test("rearm and disable");
    print_verdict();
  end
  // The whole run needs about a hundred cycles, so this bound only cuts a hang.
  initial begin
    #100000;
    err_total++;
    print_verdict();
  end
endmodule : tb_next_page_partner_ability_reg
